// ---- dv/bsr_ctl_model.sv ----
// Purpose: memory controller model on the sram pins
// Assumes: single-clock mode, main clock pair period 80 ns
// Notes: released buses show inverted values between transfers
`timescale 1ns/1ps
module bsr_ctl_model
#(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 36,
   parameter int NB = 4
)
(
   // clocks
   output logic k,
   output logic k_n,
   output logic c,
   output logic c_n,
   // commands and write data
   output logic read_n,
   output logic write_n,
   output logic [ADDR_W-1:0] address_bus,
   output logic [DATA_W-1:0] d,
   output logic [NB-1:0] byte_lane_write_n,
   // read return
   input wire logic [DATA_W-1:0] q,
   input wire logic q_oe,
   input wire logic echo_clock
);
   logic run = 1'b0;
   logic pend = 1'b0;
   int hcnt = 0;
   int ph = 2;
   event e_pre;
   event e_mid;
   logic [DATA_W-1:0] rxq[$];
   int rxh[$];

   initial
   begin
      k = 1'b0;
      k_n = 1'b0;
      c = 1'b1;
      c_n = 1'b1;
      read_n = 1'b1;
      write_n = 1'b1;
      address_bus = '0;
      d = '0;
      byte_lane_write_n = '1;
      #3;
      forever
      begin
         #20;
         if (run)
         begin
            ph = (ph + 1) % 4;
            // each pin high 20 ns in turn, so the pair never rests long enough to stop the loop
            k = (ph == 0);
            k_n = (ph == 2);
            if (ph == 0 || ph == 2)
               hcnt++;
            if (ph == 1)
               -> e_mid;
            if (ph == 3)
            begin
               if (!pend)
               begin
                  // hold time over: selects off, stale buses inverted
                  read_n = 1'b1;
                  write_n = 1'b1;
                  address_bus = ~address_bus;
                  d = ~d;
                  byte_lane_write_n = ~byte_lane_write_n;
               end
               -> e_pre;
            end
         end
      end
   end

   // one main clock cycle: command and beat0 before the true rise, then beat1
   task automatic cyc(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr, input logic [ADDR_W-1:0] wa,
      input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1, input logic [NB-1:0] l0,
      input logic [NB-1:0] l1, output int h);
      pend = 1'b1;
      @(e_pre);
      pend = 1'b0;
      read_n = !rd;
      write_n = !wr;
      address_bus = rd ? ra : ~address_bus;
      d = wr ? d0 : ~d;
      byte_lane_write_n = wr ? l0 : ~byte_lane_write_n;
      @(e_mid);
      h = hcnt;
      read_n = 1'b1;
      write_n = 1'b1;
      if (wr)
      begin
         address_bus = wa;
         d = d1;
         byte_lane_write_n = l1;
      end
   endtask

   always @(echo_clock)
   begin
      #1;
      if (q_oe === 1'b1)
      begin
         rxq.push_back(q);
         rxh.push_back(hcnt);
      end
   end
endmodule

// ---- dv/bsr_ports_chk.sv ----
// Purpose: port assertions for the sram port block
// Assumes: one clock domain, single-clock mode at the pins
// Notes: pin delays allow for the two-flop synchroniser
`timescale 1ns/1ps
module bsr_ports_chk
import bsr_pkg::*;
#(
   parameter int DATA_W = 36
)
(
   // system
   input wire logic CLK_SYS,
   input wire logic RSTN,
   // bus
   input wire logic WB_CYC,
   input wire logic WB_STB,
   input wire logic WB_ACK,
   // pins
   input wire logic K,
   input wire logic K_N,
   input wire logic [DATA_W-1:0] Q,
   input wire logic Q_OE,
   input wire logic ECHO_CLOCK,
   input wire logic ECHO_CLOCK_INVERTED,
   input wire logic [3:0] IMP_CODE
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RSTN);
   a_echo_pair:
      assert property (ECHO_CLOCK_INVERTED == !ECHO_CLOCK) else $error("echo pair not complementary");
   a_echo_rise:
      assert property ($rose(K) |-> ##[2:6] $rose(ECHO_CLOCK)) else $error("echo missed true edge");
   a_echo_fall:
      assert property ($rose(K_N) |-> ##[2:6] $fell(ECHO_CLOCK)) else $error("echo missed inverted edge");
   a_ack_answer:
      assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK) else $error("bus request not answered");
   a_ack_pulse:
      assert property (WB_ACK |=> !WB_ACK) else $error("ack longer than one cycle");
   a_ack_cause:
      assert property (!(WB_CYC && WB_STB) |=> !WB_ACK) else $error("ack without request");
   a_reset_state:
      assert property ($rose(RSTN) |-> IMP_CODE == BSR_IMP_MID && !Q_OE && !ECHO_CLOCK)
      else $error("wrong state after reset");
   a_oe_on_edge:
      assert property ($changed(Q_OE) |-> $changed(ECHO_CLOCK)) else $error("output enable off echo edge");
   a_q_on_edge:
      assert property ($changed(Q) |-> $changed(ECHO_CLOCK)) else $error("read data off echo edge");
   a_oe_two_beats:
      assert property ($rose(Q_OE) |-> Q_OE[*8]) else $error("read burst shorter than two beats");
endmodule

bind bsr_ports bsr_ports_chk #(.DATA_W(DATA_W)) u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .WB_CYC(WB_CYC),
   .WB_STB(WB_STB), .WB_ACK(WB_ACK), .K(K), .K_N(K_N), .Q(Q), .Q_OE(Q_OE), .ECHO_CLOCK(ECHO_CLOCK),
   .ECHO_CLOCK_INVERTED(ECHO_CLOCK_INVERTED), .IMP_CODE(IMP_CODE));

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench for the sram port block
// Assumes: default widths, single-clock mode
// Notes: read latency is counted in half cycles of the main clock
`timescale 1ns/1ps
module tb_top;
   import bsr_pkg::*;
   localparam logic [19:0] A = 20'h00100;
   localparam logic [35:0] DV [8] = '{36'ha5a5a5a5a, 36'h5a5a5a5a5, 36'h0f0f0f0f0, 36'hf0f0f0f0f,
      36'h123456789, 36'hfedcba987, 36'h0aa55aa55, 36'h333333333};
   logic CLK_SYS = 1'b0;
   logic RSTN = 1'b0;
   logic WB_CYC = 1'b0;
   logic WB_STB = 1'b0;
   logic WB_WE = 1'b0;
   logic DLL_OFF_N = 1'b1;
   logic [7:0] WB_ADR = 8'h00;
   logic [3:0] WB_SEL = 4'hf;
   logic [31:0] WB_DAT_I = 32'h0;
   logic [31:0] WB_DAT_O;
   logic [31:0] rv;
   logic WB_ACK, K, K_N, C, C_N, READ_N, WRITE_N, Q_OE, ECHO_CLOCK, ECHO_CLOCK_INVERTED;
   logic [19:0] ADDRESS_BUS;
   logic [35:0] D, Q;
   logic [3:0] BYTE_LANE_WRITE_N, IMP_CODE;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   bsr_ports DUT (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE),
      .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK),
      .K(K), .K_N(K_N), .C(C), .C_N(C_N), .DLL_OFF_N(DLL_OFF_N), .READ_N(READ_N), .WRITE_N(WRITE_N),
      .ADDRESS_BUS(ADDRESS_BUS), .D(D), .BYTE_LANE_WRITE_N(BYTE_LANE_WRITE_N), .Q(Q), .Q_OE(Q_OE),
      .ECHO_CLOCK(ECHO_CLOCK), .ECHO_CLOCK_INVERTED(ECHO_CLOCK_INVERTED), .IMP_CODE(IMP_CODE));
   bsr_ctl_model u_ctl (.k(K), .k_n(K_N), .c(C), .c_n(C_N), .read_n(READ_N), .write_n(WRITE_N),
      .address_bus(ADDRESS_BUS), .d(D), .byte_lane_write_n(BYTE_LANE_WRITE_N), .q(Q), .q_oe(Q_OE),
      .echo_clock(ECHO_CLOCK));

   initial
   begin
      forever #4 CLK_SYS = ~CLK_SYS;
   end

   always @(posedge CLK_SYS)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         num_errors++;
         final_report();
      end
   end

   task automatic final_report();
      if (num_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat);
      @(posedge CLK_SYS);
      WB_CYC <= 1'b1;
      WB_STB <= 1'b1;
      WB_WE <= we;
      WB_ADR <= a;
      WB_DAT_I <= dat;
      do @(posedge CLK_SYS); while (WB_ACK !== 1'b1);
      rv = WB_DAT_O;
      WB_CYC <= 1'b0;
      WB_STB <= 1'b0;
   endtask

   task automatic wait_k(input int n);
      repeat (n) @(posedge K);
   endtask

   function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n, input logic [3:0] ln);
      for (int i = 0; i < 4; i++)
         if (!ln[i])
            o[i*9 +: 9] = n[i*9 +: 9];
      return o;
   endfunction

   task automatic wr(input logic [19:0] a, input logic [35:0] d0, input logic [35:0] d1, input logic [3:0] l0,
      input logic [3:0] l1);
      int h;
      u_ctl.cyc(1'b0, 20'h0, 1'b1, a, d0, d1, l0, l1, h);
   endtask

   task automatic rd_chk(input logic [19:0] ra, input logic wen, input logic [35:0] w0, input logic [35:0] w1,
      input logic [35:0] e0, input logic [35:0] e1, input int lat);
      int h;
      u_ctl.rxq.delete();
      u_ctl.rxh.delete();
      u_ctl.cyc(1'b1, ra, wen, ra, w0, w1, 4'h0, 4'h0, h);
      wait_k(4);
      chk("beat0", e0, u_ctl.rxq[0]);
      chk("beat1", e1, u_ctl.rxq[1]);
      chk("beat0 latency", 36'(lat), 36'(u_ctl.rxh[0] - h));
      chk("beat1 latency", 36'(lat + 1), 36'(u_ctl.rxh[1] - h));
      chk("beat count", 36'h2, 36'(u_ctl.rxq.size()));
   endtask

   task automatic t_regs();
      wb(1'b0, BSR_CTRL_OFS, 32'h0);
      chk("ctrl reset", 36'(BSR_CTRL_TGT_RST), 36'(rv));
      wb(1'b0, BSR_STAT_OFS, 32'h0);
      chk("ready at reset", 36'h0, 36'(rv[BSR_STAT_READY_BIT]));
      chk("output clock mode", 36'h0, 36'(rv[BSR_STAT_CMODE_BIT]));
      chk("status code", 36'(BSR_IMP_MID), 36'(rv[BSR_STAT_IMPCODE_LSB +: 4]));
      wb(1'b1, 8'h08, 32'hffffffff);
      wb(1'b0, 8'h08, 32'h0);
      chk("unmapped", 36'h0, 36'(rv));
      wb(1'b1, BSR_CTRL_OFS, 32'h83);
      wb(1'b0, BSR_CTRL_OFS, 32'h0);
      chk("ctrl", 36'h3, 36'(rv));
   endtask

   task automatic t_init();
      wait_k(1030);
      chk("impedance code", 36'h3, 36'(IMP_CODE));
      wb(1'b0, BSR_STAT_OFS, 32'h0);
      chk("impedance done", 36'h1, 36'(rv[BSR_STAT_IMPDONE_BIT]));
      chk("early lock", 36'h0, 36'(rv[BSR_STAT_LOCKED_BIT]));
      wait_k(1040);
      wb(1'b0, BSR_STAT_OFS, 32'h0);
      chk("locked", 36'h1, 36'(rv[BSR_STAT_LOCKED_BIT]));
      chk("ready", 36'h1, 36'(rv[BSR_STAT_READY_BIT]));
   endtask

   task automatic t_data();
      wr(A, DV[0], DV[1], 4'h0, 4'h0);
      rd_chk(A, 1'b0, 36'h0, 36'h0, DV[0], DV[1], 3);
      wait_k(4);
      rd_chk(A, 1'b0, 36'h0, 36'h0, DV[0], DV[1], 3);
      wr(A + 20'h2, DV[2], DV[3], 4'h0, 4'h0);
      wait_k(4);
      rd_chk(A + 20'h1, 1'b0, 36'h0, 36'h0, DV[1], DV[2], 3);
      wr(A, DV[4], DV[5], 4'h5, 4'ha);
      rd_chk(A, 1'b0, 36'h0, 36'h0, merge(DV[0], DV[4], 4'h5), merge(DV[1], DV[5], 4'ha), 3);
      rd_chk(A, 1'b1, DV[6], DV[7], DV[6], DV[7], 3);
   endtask

   task automatic t_b2b();
      int h;
      int h2;
      u_ctl.rxq.delete();
      u_ctl.rxh.delete();
      u_ctl.cyc(1'b1, A + 20'h2, 1'b0, A, 36'h0, 36'h0, 4'hf, 4'hf, h);
      u_ctl.cyc(1'b1, A, 1'b1, A + 20'h8, DV[0], DV[1], 4'h0, 4'h0, h2);
      wait_k(5);
      chk("b2b beat0", DV[2], u_ctl.rxq[0]);
      chk("b2b beat1", DV[3], u_ctl.rxq[1]);
      chk("b2b beat2", DV[6], u_ctl.rxq[2]);
      chk("b2b beat3", DV[7], u_ctl.rxq[3]);
      chk("b2b last latency", 36'h4, 36'(u_ctl.rxh[3] - h2));
   endtask

   task automatic t_dll();
      @(posedge CLK_SYS);
      DLL_OFF_N <= 1'b0;
      wait_k(4);
      wb(1'b0, BSR_STAT_OFS, 32'h0);
      chk("bypass", 36'h1, 36'(rv[BSR_STAT_BYPASS_BIT]));
      chk("bypass ready", 36'h1, 36'(rv[BSR_STAT_READY_BIT]));
      rd_chk(A + 20'h2, 1'b0, 36'h0, 36'h0, DV[2], DV[3], 2);
      @(posedge CLK_SYS);
      DLL_OFF_N <= 1'b1;
      wait_k(4);
      wb(1'b0, BSR_STAT_OFS, 32'h0);
      chk("relock", 36'h0, 36'(rv[BSR_STAT_LOCKED_BIT]));
      chk("bypass off", 36'h0, 36'(rv[BSR_STAT_BYPASS_BIT]));
   endtask

   initial
   begin
      repeat (20) @(posedge CLK_SYS);
      RSTN <= 1'b1;
      repeat (5) @(posedge CLK_SYS);
      u_ctl.run = 1'b1;
      t_regs();
      t_init();
      t_data();
      t_b2b();
      t_dll();
      final_report();
   end
endmodule

// ---- hdl/bsr_array.sv ----
// Purpose: storage array with one asynchronous read port and two byte-masked write ports
// Assumes: the two write addresses differ whenever both write the same lane
// Notes: one array per byte lane so each lane has a single writer process
`timescale 1ns/1ps
module bsr_array
#(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 36,
   parameter int NB = 4
)
(
   // clock
   input wire logic clk,
   // read port
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data,
   // write ports
   input wire logic [ADDR_W-1:0] wa0,
   input wire logic [DATA_W-1:0] wd0,
   input wire logic [NB-1:0] we0,
   input wire logic [ADDR_W-1:0] wa1,
   input wire logic [DATA_W-1:0] wd1,
   input wire logic [NB-1:0] we1
);
   localparam int LW = DATA_W / NB;

   genvar l;
   generate
      for (l = 0; l < NB; l++)
      begin : g_lane
         logic [LW-1:0] lane_mem [0:(1<<ADDR_W)-1];
         always_ff @(posedge clk)
         begin
            if (we0[l])
            begin
               lane_mem[wa0] <= wd0[l*LW +: LW];
            end
            if (we1[l])
            begin
               lane_mem[wa1] <= wd1[l*LW +: LW];
            end
         end
         assign rd_data[l*LW +: LW] = lane_mem[rd_addr];
      end
   endgenerate
endmodule

// ---- hdl/bsr_pkg.sv ----
// Purpose: shared constants and types for the burst-of-two sram port block
// Assumes: 125 MHz system clock, classic wishbone register access
// Notes: times are kept in their own unit and turned into cycle counts here
package bsr_pkg;

   // register map, byte addresses
   localparam logic [7:0] BSR_CTRL_OFS = 8'h00;
   localparam logic [7:0] BSR_STAT_OFS = 8'h04;

   // control register fields
   localparam int BSR_CTRL_TGT_LSB = 0;
   localparam int BSR_CTRL_RECAL_BIT = 7;
   localparam logic [3:0] BSR_CTRL_TGT_RST = 4'h8;

   // status register fields
   localparam int BSR_STAT_LOCKED_BIT = 0;
   localparam int BSR_STAT_READY_BIT = 1;
   localparam int BSR_STAT_BYPASS_BIT = 2;
   localparam int BSR_STAT_CMODE_BIT = 3;
   localparam int BSR_STAT_IMPDONE_BIT = 4;
   localparam int BSR_STAT_IMPCODE_LSB = 8;

   // impedance code at power-up, middle of the range
   localparam logic [3:0] BSR_IMP_MID = 4'h8;

   // timing
   localparam int BSR_SYS_PERIOD_NS = 8;
   localparam int BSR_K_STOP_NS = 30;
   localparam int BSR_K_STOP_CYC = (BSR_K_STOP_NS + BSR_SYS_PERIOD_NS - 1) / BSR_SYS_PERIOD_NS;
   localparam int BSR_LOCK_WAIT_CYCLES = 2048;
   localparam int BSR_IMP_SETTLE_CYCLES = 1024;
   localparam logic [1:0] BSR_WR_COMMIT_AGE = 2'h3;

   typedef enum logic [1:0] {DLL_BYPASS, DLL_LOCKING, DLL_LOCKED} bsr_dll_t;

endpackage

// ---- hdl/bsr_ports.sv ----
// Purpose: pin-side port logic of a burst-of-two ddr sram with separate read and write ports
// Assumes: all pins sampled by CLK_SYS through two flops; pin clocks far slower than CLK_SYS
// Notes: control and status reached over classic wishbone
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module bsr_ports
import bsr_pkg::*;
#(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 36,
   parameter int NB = 4,
   parameter int RD_SLOTS = 3,
   parameter int WB_DEPTH = 3
)
(
   // system
   input wire logic CLK_SYS,
   input wire logic RSTN,
   // wishbone slave
   input wire logic WB_CYC,
   input wire logic WB_STB,
   input wire logic WB_WE,
   input wire logic [7:0] WB_ADR,
   input wire logic [3:0] WB_SEL,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK,
   // clock pins
   input wire logic K,
   input wire logic K_N,
   input wire logic C,
   input wire logic C_N,
   input wire logic DLL_OFF_N,
   // command and write pins
   input wire logic READ_N,
   input wire logic WRITE_N,
   input wire logic [ADDR_W-1:0] ADDRESS_BUS,
   input wire logic [DATA_W-1:0] D,
   input wire logic [NB-1:0] BYTE_LANE_WRITE_N,
   // read data and echo pins
   output logic [DATA_W-1:0] Q,
   output logic Q_OE,
   output logic ECHO_CLOCK,
   output logic ECHO_CLOCK_INVERTED,
   // driver impedance code
   output logic [3:0] IMP_CODE
);
   import bsr_pkg::*;

   localparam int LW = DATA_W / NB;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [1:0] ninv;
      logic sent0;
   } bsr_rslot_t;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] d0;
      logic [DATA_W-1:0] d1;
      logic [NB-1:0] bw0;
      logic [NB-1:0] bw1;
      logic [1:0] age;
   } bsr_went_t;

   typedef struct packed {
      logic k_m, k_s, k_p;
      logic kn_m, kn_s, kn_p;
      logic c_m, c_s, c_p;
      logic cn_m, cn_s, cn_p;
      logic doff_m, doff_s, doff_p;
      logic r_m, r_s;
      logic w_m, w_s;
      logic [ADDR_W-1:0] a_m, a_s;
      logic [DATA_W-1:0] d_m, d_s;
      logic [NB-1:0] bw_m, bw_s;
      logic c_used;
      bsr_rslot_t [RD_SLOTS-1:0] rslot;
      bsr_went_t [WB_DEPTH-1:0] went;
      logic wpend;
      logic [DATA_W-1:0] wd0;
      logic [NB-1:0] wbw0;
      logic [DATA_W-1:0] q;
      logic q_oe;
      logic cq;
      logic [2:0] idle;
      bsr_dll_t dll_st;
      logic [11:0] lock_cnt;
      logic [11:0] init_cnt;
      logic init_done;
      logic [10:0] imp_cnt;
      logic [3:0] imp_code;
      logic imp_done;
      logic [3:0] imp_tgt;
      logic wb_ack;
      logic [31:0] wb_dat;
   } bsr_state_t;

   bsr_state_t s;
   bsr_state_t next_s;

   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic [ADDR_W-1:0] wa0;
   logic [ADDR_W-1:0] wa1;
   logic [DATA_W-1:0] wd0;
   logic [DATA_W-1:0] wd1;
   logic [NB-1:0] we0;
   logic [NB-1:0] we1;

   // newer buffered bytes overlay older ones and the array word
   function automatic logic [DATA_W-1:0] bsr_merge(input logic [DATA_W-1:0] base,
                                                   input logic [ADDR_W-1:0] a,
                                                   input bsr_went_t [WB_DEPTH-1:0] e);
      logic [DATA_W-1:0] w;
      w = base;
      for (int i = WB_DEPTH - 1; i >= 0; i--)
      begin
         for (int b = 0; b < NB; b++)
         begin
            if (e[i].valid && e[i].addr == a && !e[i].bw0[b])
            begin
               w[b*LW +: LW] = e[i].d0[b*LW +: LW];
            end
            if (e[i].valid && ADDR_W'(e[i].addr + 1'b1) == a && !e[i].bw1[b])
            begin
               w[b*LW +: LW] = e[i].d1[b*LW +: LW];
            end
         end
      end
      return w;
   endfunction

   always_comb
   begin
      logic k_rise, kn_rise, o_true, o_inv, bypass, launch, taken, acc;
      logic [ADDR_W-1:0] launch_addr;
      k_rise = 1'b0;
      kn_rise = 1'b0;
      o_true = 1'b0;
      o_inv = 1'b0;
      bypass = 1'b0;
      launch = 1'b0;
      taken = 1'b0;
      acc = 1'b0;
      launch_addr = '0;
      next_s = s;
      wa0 = '0;
      wa1 = '0;
      wd0 = '0;
      wd1 = '0;
      we0 = '0;
      we1 = '0;

      // pin synchronisers
      next_s.k_m = K;
      next_s.k_s = s.k_m;
      next_s.k_p = s.k_s;
      next_s.kn_m = K_N;
      next_s.kn_s = s.kn_m;
      next_s.kn_p = s.kn_s;
      next_s.c_m = C;
      next_s.c_s = s.c_m;
      next_s.c_p = s.c_s;
      next_s.cn_m = C_N;
      next_s.cn_s = s.cn_m;
      next_s.cn_p = s.cn_s;
      next_s.doff_m = DLL_OFF_N;
      next_s.doff_s = s.doff_m;
      next_s.doff_p = s.doff_s;
      next_s.r_m = READ_N;
      next_s.r_s = s.r_m;
      next_s.w_m = WRITE_N;
      next_s.w_s = s.w_m;
      next_s.a_m = ADDRESS_BUS;
      next_s.a_s = s.a_m;
      next_s.d_m = D;
      next_s.d_s = s.d_m;
      next_s.bw_m = BYTE_LANE_WRITE_N;
      next_s.bw_s = s.bw_m;

      // rising edges of each clock polarity
      k_rise = s.k_s & ~s.k_p;
      kn_rise = s.kn_s & ~s.kn_p;
      if (!s.c_s || !s.cn_s)
      begin
         next_s.c_used = 1'b1;
      end
      o_true = s.c_used ? (s.c_s & ~s.c_p) : k_rise;
      o_inv = s.c_used ? (s.cn_s & ~s.cn_p) : kn_rise;
      bypass = (s.dll_st == DLL_BYPASS);

      // read pipeline, launches counted on output clock edges
      for (int i = 0; i < RD_SLOTS; i++)
      begin
         if (s.rslot[i].valid && o_inv)
         begin
            if (!s.rslot[i].sent0)
            begin
               if (!bypass && s.rslot[i].ninv == 2'h1)
               begin
                  launch = 1'b1;
                  launch_addr = s.rslot[i].addr;
                  next_s.rslot[i].sent0 = 1'b1;
               end
               if (s.rslot[i].ninv != 2'h3)
               begin
                  next_s.rslot[i].ninv = 2'(s.rslot[i].ninv + 1'b1);
               end
            end
            else if (bypass)
            begin
               launch = 1'b1;
               launch_addr = ADDR_W'(s.rslot[i].addr + 1'b1);
               next_s.rslot[i].valid = 1'b0;
            end
         end
         if (s.rslot[i].valid && o_true)
         begin
            if (s.rslot[i].sent0 && !bypass)
            begin
               launch = 1'b1;
               launch_addr = ADDR_W'(s.rslot[i].addr + 1'b1);
               next_s.rslot[i].valid = 1'b0;
            end
            else if (!s.rslot[i].sent0 && bypass && s.rslot[i].ninv != 2'h0)
            begin
               launch = 1'b1;
               launch_addr = s.rslot[i].addr;
               next_s.rslot[i].sent0 = 1'b1;
            end
         end
      end

      // new read takes a free slot; idle cycles leave slots alone
      if (k_rise && !s.r_s)
      begin
         for (int i = 0; i < RD_SLOTS; i++)
         begin
            if (!next_s.rslot[i].valid && !taken)
            begin
               taken = 1'b1;
               next_s.rslot[i].valid = 1'b1;
               next_s.rslot[i].addr = s.a_s;
               next_s.rslot[i].ninv = 2'h0;
               next_s.rslot[i].sent0 = 1'b0;
            end
         end
      end

      rd_addr = launch_addr;
      if (o_true || o_inv)
      begin
         next_s.q_oe = launch;
         if (launch)
         begin
            next_s.q = bsr_merge(rd_data, launch_addr, s.went);
         end
      end

      // echo clocks follow output edges whether or not data is driven
      if (o_true)
      begin
         next_s.cq = 1'b1;
      end
      if (o_inv)
      begin
         next_s.cq = 1'b0;
      end

      // commit of the oldest buffer entry, both beats at once
      for (int i = 0; i < WB_DEPTH; i++)
      begin
         if (s.went[i].valid && s.went[i].age == BSR_WR_COMMIT_AGE)
         begin
            wa0 = s.went[i].addr;
            wa1 = ADDR_W'(s.went[i].addr + 1'b1);
            wd0 = s.went[i].d0;
            wd1 = s.went[i].d1;
            we0 = ~s.went[i].bw0;
            we1 = ~s.went[i].bw1;
            next_s.went[i].valid = 1'b0;
         end
         if (k_rise && s.went[i].valid && s.went[i].age != BSR_WR_COMMIT_AGE)
         begin
            next_s.went[i].age = 2'(s.went[i].age + 1'b1);
         end
      end

      // write capture: beat0 with the command, address and beat1 half a cycle on
      if (k_rise && !s.w_s)
      begin
         next_s.wpend = 1'b1;
         next_s.wd0 = s.d_s;
         next_s.wbw0 = s.bw_s;
      end
      if (kn_rise && s.wpend)
      begin
         for (int i = WB_DEPTH - 1; i > 0; i--)
         begin
            next_s.went[i] = next_s.went[i-1];
         end
         next_s.went[0].valid = 1'b1;
         next_s.went[0].addr = s.a_s;
         next_s.went[0].d0 = s.wd0;
         next_s.went[0].d1 = s.d_s;
         next_s.went[0].bw0 = s.wbw0;
         next_s.went[0].bw1 = s.bw_s;
         next_s.went[0].age = 2'h0;
         next_s.wpend = 1'b0;
      end

      // delay-lock loop
      if (s.k_s != s.k_p || s.kn_s != s.kn_p)
      begin
         next_s.idle = 3'h0;
      end
      else if (s.idle != 3'(BSR_K_STOP_CYC))
      begin
         next_s.idle = 3'(s.idle + 1'b1);
      end
      case (s.dll_st)
         DLL_BYPASS:
         begin
            if (s.doff_s && !s.doff_p)
            begin
               next_s.dll_st = DLL_LOCKING;
               next_s.lock_cnt = 12'h000;
            end
         end
         DLL_LOCKING:
         begin
            if (!s.doff_s)
            begin
               next_s.dll_st = DLL_BYPASS;
            end
            else if (k_rise)
            begin
               next_s.lock_cnt = 12'(s.lock_cnt + 1'b1);
               if (s.lock_cnt == 12'(BSR_LOCK_WAIT_CYCLES - 1))
               begin
                  next_s.dll_st = DLL_LOCKED;
               end
            end
         end
         default:
         begin
            if (!s.doff_s)
            begin
               next_s.dll_st = DLL_BYPASS;
            end
         end
      endcase
      if (s.doff_s && next_s.idle == 3'(BSR_K_STOP_CYC))
      begin
         next_s.dll_st = DLL_LOCKING;
         next_s.lock_cnt = 12'h000;
      end

      // initialisation wait after reset
      if (!s.init_done && k_rise)
      begin
         next_s.init_cnt = 12'(s.init_cnt + 1'b1);
         if (s.init_cnt == 12'(BSR_LOCK_WAIT_CYCLES - 1))
         begin
            next_s.init_done = 1'b1;
         end
      end

      // impedance settling, then tracks the target
      if (!s.imp_done && k_rise)
      begin
         next_s.imp_cnt = 11'(s.imp_cnt + 1'b1);
         if (s.imp_cnt == 11'(BSR_IMP_SETTLE_CYCLES - 1))
         begin
            next_s.imp_done = 1'b1;
            next_s.imp_code = s.imp_tgt;
         end
      end
      else if (s.imp_done)
      begin
         next_s.imp_code = s.imp_tgt;
      end

      // wishbone slave, one wait state, ack drops after one cycle
      next_s.wb_ack = 1'b0;
      if (WB_CYC && WB_STB && !s.wb_ack)
      begin
         acc = 1'b1;
      end
      if (acc)
      begin
         next_s.wb_ack = 1'b1;
         next_s.wb_dat = 32'h0000_0000;
         if (WB_ADR == BSR_CTRL_OFS)
         begin
            next_s.wb_dat[BSR_CTRL_TGT_LSB +: 4] = s.imp_tgt;
            if (WB_WE && WB_SEL[0])
            begin
               next_s.imp_tgt = WB_DAT_I[BSR_CTRL_TGT_LSB +: 4];
               if (WB_DAT_I[BSR_CTRL_RECAL_BIT])
               begin
                  next_s.imp_done = 1'b0;
                  next_s.imp_cnt = 11'h000;
                  next_s.imp_code = BSR_IMP_MID;
               end
            end
         end
         else if (WB_ADR == BSR_STAT_OFS)
         begin
            next_s.wb_dat[BSR_STAT_LOCKED_BIT] = (s.dll_st == DLL_LOCKED);
            next_s.wb_dat[BSR_STAT_READY_BIT] = s.init_done & (bypass | (s.dll_st == DLL_LOCKED));
            next_s.wb_dat[BSR_STAT_BYPASS_BIT] = bypass;
            next_s.wb_dat[BSR_STAT_CMODE_BIT] = s.c_used;
            next_s.wb_dat[BSR_STAT_IMPDONE_BIT] = s.imp_done;
            next_s.wb_dat[BSR_STAT_IMPCODE_LSB +: 4] = s.imp_code;
         end
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         s <= '0;
         s.c_m <= 1'b1;
         s.c_s <= 1'b1;
         s.c_p <= 1'b1;
         s.cn_m <= 1'b1;
         s.cn_s <= 1'b1;
         s.cn_p <= 1'b1;
         s.r_m <= 1'b1;
         s.r_s <= 1'b1;
         s.w_m <= 1'b1;
         s.w_s <= 1'b1;
         // disable pin idles high, so no false rise or bypass dip after reset
         s.doff_m <= 1'b1;
         s.doff_s <= 1'b1;
         s.doff_p <= 1'b1;
         s.dll_st <= DLL_LOCKING;
         s.imp_code <= BSR_IMP_MID;
         s.imp_tgt <= BSR_CTRL_TGT_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   bsr_array #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .NB(NB)) u_array
   (
      .clk(CLK_SYS),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .wa0(wa0),
      .wd0(wd0),
      .we0(we0),
      .wa1(wa1),
      .wd1(wd1),
      .we1(we1)
   );

   assign WB_ACK = s.wb_ack;
   assign WB_DAT_O = s.wb_dat;
   assign Q = s.q;
   assign Q_OE = s.q_oe;
   assign ECHO_CLOCK = s.cq;
   assign ECHO_CLOCK_INVERTED = ~s.cq;
   assign IMP_CODE = s.imp_code;
endmodule
